// >>> rtl/sbc_readback_pkg.sv
/*
 * Constants shared by the status and diagnosis read-back block: frame
 * header codes, word layouts, reset-source codes and reset values.
 * Assumes a serial shift engine on the same clock that decodes frames.
 */
package sbc_readback_pkg;

    // ------------------------------------------------------------
    // Frame header
    // ------------------------------------------------------------
    localparam logic [1:0]  ADDR_SYSTEM      = 2'h0;
    localparam int          FRAME_CLOCKS     = 16;
    localparam int          PAYLOAD_WIDTH    = 12;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int          BIT_ADDR_HI      = 15;
    localparam int          BIT_ADDR_LO      = 14;
    localparam int          BIT_READ_SELECT  = 13;
    localparam int          BIT_READ_ONLY    = 12;
    localparam int          BIT_SRC_HI       = 11;
    localparam int          BIT_SRC_LO       = 8;
    localparam int          BIT_LIN_WAKE     = 6;
    localparam int          BIT_EDGE_WAKE    = 5;
    localparam int          BIT_WAKE_LEVEL   = 4;
    localparam int          BIT_TEMP_WARN    = 3;
    localparam int          BIT_DEV_MODE     = 2;
    localparam int          BIT_ENABLE_OUT   = 1;
    localparam int          BIT_POWER_ON     = 0;
    localparam int          BIT_LIN_FAULT_HI = 6;
    localparam int          BIT_LIN_FAULT_LO = 5;
    localparam int          BIT_SEC_HEALTH   = 4;
    localparam int          BIT_DIAG_ONE     = 3;
    localparam int          BIT_MAIN_HEALTH  = 2;
    localparam logic [4:0]  DIAG_RSVD_HI     = 5'h00;
    localparam logic        DIAG_RSVD_3      = 1'b1;
    localparam logic [1:0]  DIAG_RSVD_LO     = 2'h0;
    localparam logic        STATUS_RSVD_7    = 1'b0;

    // ------------------------------------------------------------
    // Reset-source codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  SRC_POWER_ON     = 4'h0;
    localparam logic [3:0]  SRC_WD_INIT      = 4'hc;
    localparam logic [3:0]  SRC_WD_EARLY     = 4'hd;
    localparam logic [3:0]  SRC_ILLEGAL_SPI  = 4'he;
    localparam logic [3:0]  SRC_INT_TIMEOUT  = 4'hf;
    localparam logic        POWER_ON_RESET   = 1'b1;
    localparam logic [15:0] WORD_RESET       = 16'h0000;
    localparam logic [11:0] PAYLOAD_RESET    = 12'h000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } frame_state_type;

endpackage

// >>> rtl/sticky_flag_if.sv
/*
 * Carrier between the read-back top and one sticky event flag: set and
 * clear requests going in, the held flag coming back.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
interface sticky_flag_if;
    logic set;
    logic clear;
    logic flag;

    modport keeper
    (
        input  set,
        input  clear,
        output flag
    );
    modport user
    (
        output set,
        output clear,
        input  flag
    );
endinterface

// >>> rtl/sticky_flag.sv
/*
 * One sticky event flag: a set pulse raises it, a clear pulse drops it,
 * and a set in the same cycle as a clear wins.
 * Assumes set and clear come from logic on CLK_SYS_I.
 */
`timescale 1ns/10ps
module sticky_flag
    import sbc_readback_pkg::*;
(
    // Clock and reset
    input  wire logic    clk_i,
    input  wire logic    rst_n_i,
    // Flag carrier
    sticky_flag_if.keeper port_if
);

    logic flag;

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    // Set beats clear so an event landing on the read is kept
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag <= 1'b0;
        else
            flag <= port_if.set | (flag & ~port_if.clear);
    end

    assign port_if.flag = flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_set_wins_clear:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        port_if.set |=> flag)
    else $error("sticky flag missed a set");

    a_clear_drops_flag:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (port_if.clear && !port_if.set) |=> !flag)
    else $error("sticky flag ignored a clear");

endmodule

// >>> rtl/sbc_status_readback.sv
/*
 * Status and diagnosis read-back for the supervisor chip. Builds the two
 * 16-bit words from live and sticky state, hands the selected word to the
 * shift engine at frame start and applies read side effects at frame end.
 * Assumes a shift engine on CLK_SYS_I that pulses frame start with the
 * header and frame end with the clock count and remaining payload bits,
 * and detectors on the same clock; only the wake pin is asynchronous.
 */
`timescale 1ns/10ps
module sbc_status_readback
    import sbc_readback_pkg::*;
#(
    parameter int FRAME_BITS = FRAME_CLOCKS
)
(
    // Clock and reset
    input  wire logic                     CLK_SYS_I,
    input  wire logic                     RST_N_I,
    // Frame from the shift engine
    input  wire logic                     FRAME_START_I,
    input  wire logic [1:0]               ADDRESS_FIELD_I,
    input  wire logic                     READ_SELECT_BIT_I,
    input  wire logic                     READ_ONLY_BIT_I,
    input  wire logic                     FRAME_END_I,
    input  wire logic [5:0]               FRAME_CLOCK_COUNT_I,
    input  wire logic [PAYLOAD_WIDTH-1:0] FRAME_PAYLOAD_I,
    input  wire logic                     FAIL_SIGNAL_ENABLE_I,
    // Reset causes
    input  wire logic                     WD_INIT_TIMEOUT_I,
    input  wire logic                     WD_EARLY_TRIGGER_I,
    input  wire logic                     ILLEGAL_ACCESS_I,
    input  wire logic                     INT_SERVICE_TIMEOUT_I,
    input  wire logic                     OTHER_RESET_I,
    input  wire logic [3:0]               OTHER_RESET_CODE_I,
    input  wire logic                     NORMAL_ENTERED_I,
    // Detectors and pins
    input  wire logic                     LIN_WAKE_EVENT_I,
    input  wire logic                     WAKE_PIN_I,
    input  wire logic                     TEMPERATURE_WARNING_I,
    input  wire logic                     DEVELOPMENT_MODE_STATE_I,
    input  wire logic                     ENABLE_OUTPUT_STATE_I,
    input  wire logic [1:0]               LIN_FAULT_FIELD_I,
    input  wire logic                     SECONDARY_REGULATOR_HEALTH_I,
    input  wire logic                     MAIN_SUPPLY_UNDERVOLTAGE_I,
    // Read-back to the shift engine
    output logic [15:0]                   READ_WORD_O,
    output logic                          READ_HIT_O,
    // Mode register write and frame failure
    output logic                          MODE_WRITE_O,
    output logic [PAYLOAD_WIDTH-1:0]      MODE_DATA_O,
    output logic                          CLOCK_COUNT_FAIL_O
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (FRAME_BITS < 1 || FRAME_BITS > 63)
        begin : g_bad_frame_bits
            $error("FRAME_BITS must fit the 6-bit clock count");
        end
    endgenerate

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    frame_state_type state;
    logic [3:0]      reset_source_field;
    logic            power_on_flag;
    logic            wake_meta;
    logic            wake_level;
    logic            wake_last;
    logic            wake_fall;
    logic            captured_diag;
    logic            captured_keep;
    logic            frame_ok;
    logic            frame_bad;
    logic            status_read_done;
    logic            diag_read_done;
    logic            main_regulator_health;
    logic [15:0]     status_word;
    logic [15:0]     diag_word;
    logic [15:0]     next_word;
    logic [5:0]      frame_bits;

    sticky_flag_if lin_wake_if ();
    sticky_flag_if edge_wake_if ();
    sticky_flag_if undervoltage_if ();

    assign frame_bits = 6'(FRAME_BITS);

    // ------------------------------------------------------------
    // Wake pin synchroniser and falling-edge detector
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wake_meta  <= 1'b1;
            wake_level <= 1'b1;
            wake_last  <= 1'b1;
        end
        else
        begin
            wake_meta  <= WAKE_PIN_I;
            wake_level <= wake_meta;
            wake_last  <= wake_level;
        end
    end

    assign wake_fall = wake_last & ~wake_level;

    // ------------------------------------------------------------
    // Reset source and power-on flag
    // ------------------------------------------------------------
    // Reads never touch this field; only reset causes overwrite it
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            reset_source_field <= SRC_POWER_ON;
        else if (WD_INIT_TIMEOUT_I)
            reset_source_field <= SRC_WD_INIT;
        else if (WD_EARLY_TRIGGER_I)
            reset_source_field <= SRC_WD_EARLY;
        else if (ILLEGAL_ACCESS_I)
            reset_source_field <= SRC_ILLEGAL_SPI;
        else if (INT_SERVICE_TIMEOUT_I)
            reset_source_field <= SRC_INT_TIMEOUT;
        else if (OTHER_RESET_I)
            reset_source_field <= OTHER_RESET_CODE_I;
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            power_on_flag <= POWER_ON_RESET;
        else if (NORMAL_ENTERED_I)
            power_on_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // A flag is cleared only if the host actually saw it set in the
    // captured word; an event after capture survives to the next read if that word showed the flag clear or it lands on the clearing cycle.
    assign lin_wake_if.set       = LIN_WAKE_EVENT_I;
    assign lin_wake_if.clear     = status_read_done & READ_WORD_O[BIT_LIN_WAKE];
    assign edge_wake_if.set      = wake_fall;
    assign edge_wake_if.clear    = status_read_done & READ_WORD_O[BIT_EDGE_WAKE];
    assign undervoltage_if.set   = MAIN_SUPPLY_UNDERVOLTAGE_I;
    assign undervoltage_if.clear = diag_read_done & ~READ_WORD_O[BIT_MAIN_HEALTH];
    assign main_regulator_health = ~undervoltage_if.flag;

    sticky_flag u_lin_wake
    (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .port_if (lin_wake_if.keeper)
    );

    sticky_flag u_edge_wake
    (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .port_if (edge_wake_if.keeper)
    );

    sticky_flag u_undervoltage
    (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .port_if (undervoltage_if.keeper)
    );

    // ------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------
    // No mode input gates these words: they read the same in every mode
    always_comb
    begin
        status_word                               = WORD_RESET;
        status_word[BIT_ADDR_HI:BIT_ADDR_LO]      = ADDRESS_FIELD_I;
        status_word[BIT_READ_SELECT]              = READ_SELECT_BIT_I;
        status_word[BIT_READ_ONLY]                = READ_ONLY_BIT_I;
        status_word[BIT_SRC_HI:BIT_SRC_LO]        = reset_source_field;
        status_word[7]                            = STATUS_RSVD_7;
        status_word[BIT_LIN_WAKE]                 = lin_wake_if.flag;
        status_word[BIT_EDGE_WAKE]                = edge_wake_if.flag;
        status_word[BIT_WAKE_LEVEL]               = wake_level;
        status_word[BIT_TEMP_WARN]                = TEMPERATURE_WARNING_I;
        status_word[BIT_DEV_MODE]                 = DEVELOPMENT_MODE_STATE_I;
        status_word[BIT_ENABLE_OUT]               = ENABLE_OUTPUT_STATE_I;
        status_word[BIT_POWER_ON]                 = power_on_flag;
    end

    always_comb
    begin
        diag_word                                 = WORD_RESET;
        diag_word[BIT_ADDR_HI:BIT_ADDR_LO]        = ADDRESS_FIELD_I;
        diag_word[BIT_READ_SELECT]                = READ_SELECT_BIT_I;
        diag_word[BIT_READ_ONLY]                  = READ_ONLY_BIT_I;
        diag_word[11:7]                           = DIAG_RSVD_HI;
        diag_word[BIT_LIN_FAULT_HI:BIT_LIN_FAULT_LO] = LIN_FAULT_FIELD_I;
        diag_word[BIT_SEC_HEALTH]                 = SECONDARY_REGULATOR_HEALTH_I;
        diag_word[BIT_DIAG_ONE]                   = DIAG_RSVD_3;
        diag_word[BIT_MAIN_HEALTH]                = main_regulator_health;
        diag_word[1:0]                            = DIAG_RSVD_LO;
    end

    always_comb
    begin
        if (ADDRESS_FIELD_I != ADDR_SYSTEM)
            next_word = WORD_RESET;
        else if (READ_SELECT_BIT_I)
            next_word = diag_word;
        else
            next_word = status_word;
    end

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (FRAME_START_I)
                        state <= ST_BUSY;
                ST_BUSY:
                    if (FRAME_END_I && !FRAME_START_I)
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    assign frame_ok  = (state == ST_BUSY) && FRAME_END_I
                       && (FRAME_CLOCK_COUNT_I == frame_bits);
    assign frame_bad = (state == ST_BUSY) && FRAME_END_I
                       && (FRAME_CLOCK_COUNT_I != frame_bits);
    assign status_read_done = frame_ok & READ_HIT_O & ~captured_diag;
    assign diag_read_done   = frame_ok & READ_HIT_O & captured_diag;

    // Capture at start so the word does not shift under the host
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            READ_WORD_O   <= WORD_RESET;
            READ_HIT_O    <= 1'b0;
            captured_diag <= 1'b0;
            captured_keep <= 1'b1;
        end
        else if (FRAME_START_I)
        begin
            READ_WORD_O   <= next_word;
            READ_HIT_O    <= (ADDRESS_FIELD_I == ADDR_SYSTEM);
            captured_diag <= READ_SELECT_BIT_I;
            captured_keep <= READ_ONLY_BIT_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            MODE_WRITE_O <= 1'b0;
            MODE_DATA_O  <= PAYLOAD_RESET;
        end
        else
        begin
            MODE_WRITE_O <= frame_ok & READ_HIT_O & ~captured_keep;
            if (frame_ok && READ_HIT_O && !captured_keep)
                MODE_DATA_O <= FRAME_PAYLOAD_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            CLOCK_COUNT_FAIL_O <= 1'b0;
        else
            CLOCK_COUNT_FAIL_O <= frame_bad & FAIL_SIGNAL_ENABLE_I;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    a_src_wd_init:
    assert property (WD_INIT_TIMEOUT_I |=> reset_source_field == 4'hc)
    else $error("init timeout code not recorded");

    a_src_wd_early:
    assert property ((WD_EARLY_TRIGGER_I && !WD_INIT_TIMEOUT_I) |=> reset_source_field == 4'hd)
    else $error("early trigger code not recorded");

    a_src_spi_int:
    assert property ((ILLEGAL_ACCESS_I && !WD_INIT_TIMEOUT_I && !WD_EARLY_TRIGGER_I)
                     ##1 (!WD_INIT_TIMEOUT_I && !WD_EARLY_TRIGGER_I && !ILLEGAL_ACCESS_I
                          && !INT_SERVICE_TIMEOUT_I && !OTHER_RESET_I)
                     |-> reset_source_field == 4'he)
    else $error("illegal access code not held");

    a_src_read_keeps:
    assert property ((frame_ok && !WD_INIT_TIMEOUT_I && !WD_EARLY_TRIGGER_I && !ILLEGAL_ACCESS_I
                      && !INT_SERVICE_TIMEOUT_I && !OTHER_RESET_I) |=> $stable(reset_source_field))
    else $error("reset source changed by a read");

    a_lin_wake_shown:
    assert property ((LIN_WAKE_EVENT_I ##1 !lin_wake_if.clear ##1 (FRAME_START_I && ADDRESS_FIELD_I == 2'h0
                      && !READ_SELECT_BIT_I)) |=> READ_WORD_O[6])
    else $error("LIN wake not shown in status");

    a_edge_wake_set:
    assert property (wake_fall |=> edge_wake_if.flag)
    else $error("wake edge not latched");

    a_power_on_clear:
    assert property (NORMAL_ENTERED_I |=> !power_on_flag ##1 !power_on_flag)
    else $error("power-on flag not cleared");

    a_diag_reserved:
    assert property ((FRAME_START_I && ADDRESS_FIELD_I == 2'h0 && READ_SELECT_BIT_I)
                     |=> READ_WORD_O[3] && READ_WORD_O[11:7] == 5'h00 && READ_WORD_O[1:0] == 2'h0)
    else $error("diagnosis reserved bits wrong");

    a_main_uv_latch:
    assert property (MAIN_SUPPLY_UNDERVOLTAGE_I |=> !main_regulator_health)
    else $error("undervoltage not latched");

    a_mode_write:
    assert property ((frame_ok && READ_HIT_O && !captured_keep) |=> MODE_WRITE_O
                     && MODE_DATA_O == $past(FRAME_PAYLOAD_I))
    else $error("mode write missing");

    a_bad_frame_quiet:
    assert property (frame_bad |=> !MODE_WRITE_O && CLOCK_COUNT_FAIL_O == $past(FAIL_SIGNAL_ENABLE_I))
    else $error("bad frame not refused");

    c_status_read:
    cover property (FRAME_START_I && !READ_SELECT_BIT_I ##[1:40] status_read_done);

    c_diag_read_restore:
    cover property (diag_read_done && !READ_WORD_O[2] ##1 main_regulator_health);

    c_bad_frame_fail:
    cover property (frame_bad && FAIL_SIGNAL_ENABLE_I);

endmodule

// >>> test/host_model.sv
/*
 * Host-side frame model: hands decoded frames to the read-back block.
 * Assumes the shared system clock; drives only on falling edges.
 */
`timescale 1ns/10ps
module host_model
(
    input  wire logic clk_i,
    output logic      start_o,
    output logic [3:0] hdr_o,
    output logic      end_o,
    output logic [5:0] count_o,
    output logic [11:0] payload_o
);
    initial
    begin
        start_o = 1'b0;
        hdr_o = 4'h5;
        end_o = 1'b0;
        count_o = 6'h2a;
        payload_o = 12'ha5a;
    end

    // Released fields are inverted so a stale value is never taken as good
    task automatic frame(input logic [3:0] hdr, input logic [5:0] cnt, input logic [11:0] pl);
        @(negedge clk_i);
        start_o = 1'b1;
        hdr_o = hdr;
        @(negedge clk_i);
        start_o = 1'b0;
        hdr_o = ~hdr;
        @(negedge clk_i);
        end_o = 1'b1;
        count_o = cnt;
        payload_o = pl;
        @(negedge clk_i);
        end_o = 1'b0;
        count_o = ~cnt;
        payload_o = ~pl;
    endtask
endmodule

// >>> test/testbench.sv
/*
 * Self-checking bench for the status and diagnosis read-back block.
 * Assumes the host model issues frames; detectors are driven here.
 */
`timescale 1ns/10ps
module testbench;
    import sbc_readback_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fail_en = 1'b1, normal = 1'b0;
    logic lin_wake = 1'b0, wake = 1'b1, temp = 1'b1, dev = 1'b0, en = 1'b1;
    logic sec = 1'b1, uv = 1'b0;
    logic [1:0] lf = 2'h0;
    logic [4:0] cause = 5'h00;
    logic [3:0] src, hdr;
    logic st_, en_;
    logic [5:0] cnt;
    logic [11:0] pl, mdata;
    logic [15:0] word;
    logic hit, mw, fail;
    int miscompares = 0, checked = 0;

    initial
    begin
        forever #4 clk = ~clk;
    end

    host_model i_host (.clk_i(clk), .start_o(st_), .hdr_o(hdr), .end_o(en_), .count_o(cnt), .payload_o(pl));

    sbc_status_readback i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .FRAME_START_I(st_),
        .ADDRESS_FIELD_I(hdr[3:2]), .READ_SELECT_BIT_I(hdr[1]), .READ_ONLY_BIT_I(hdr[0]),
        .FRAME_END_I(en_), .FRAME_CLOCK_COUNT_I(cnt), .FRAME_PAYLOAD_I(pl), .FAIL_SIGNAL_ENABLE_I(fail_en),
        .WD_INIT_TIMEOUT_I(cause[0]), .WD_EARLY_TRIGGER_I(cause[1]), .ILLEGAL_ACCESS_I(cause[2]),
        .INT_SERVICE_TIMEOUT_I(cause[3]), .OTHER_RESET_I(cause[4]), .OTHER_RESET_CODE_I(4'h9),
        .NORMAL_ENTERED_I(normal), .LIN_WAKE_EVENT_I(lin_wake), .WAKE_PIN_I(wake),
        .TEMPERATURE_WARNING_I(temp), .DEVELOPMENT_MODE_STATE_I(dev), .ENABLE_OUTPUT_STATE_I(en),
        .LIN_FAULT_FIELD_I(lf), .SECONDARY_REGULATOR_HEALTH_I(sec), .MAIN_SUPPLY_UNDERVOLTAGE_I(uv),
        .READ_WORD_O(word), .READ_HIT_O(hit), .MODE_WRITE_O(mw), .MODE_DATA_O(mdata),
        .CLOCK_COUNT_FAIL_O(fail));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    function automatic logic [15:0] st(logic [3:0] h, logic lw, logic ew, logic wl, logic po);
        return {h, src, 1'b0, lw, ew, wl, temp, dev, en, po};
    endfunction

    function automatic logic [15:0] dg(logic mh);
        return {4'h3, 5'h00, lf, sec, 1'b1, mh, 2'h0};
    endfunction

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #20000;
        miscompares++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        src = 4'h0;
        i_host.frame(4'h1, 6'd16, 12'h3c5);
        chk(st(4'h1, 1'b0, 1'b0, 1'b1, 1'b1), word);
        chk({15'h0, hit}, 16'h1);
        $display("reset values done");
        for (int i = 0; i < 5; i++)
        begin
            @(negedge clk);
            cause = 5'h01 << i;
            @(negedge clk);
            cause = 5'h00;
            src = (i == 4) ? 4'h9 : 4'hc + 4'(i);
            repeat (2)
            begin
                i_host.frame(4'h1, 6'd16, 12'h3c5);
                chk(st(4'h1, 1'b0, 1'b0, 1'b1, 1'b1), word);
            end
        end
        $display("reset source done");
        wake = 1'b0;
        repeat (4) @(negedge clk);
        pulse(lin_wake);
        i_host.frame(4'h0, 6'd15, 12'h3c5);
        chk(st(4'h0, 1'b1, 1'b1, 1'b0, 1'b1), word);
        chk({14'h0, fail, mw}, 16'h2);
        fail_en = 1'b0;
        i_host.frame(4'h0, 6'd17, 12'h3c5);
        chk({14'h0, fail, mw}, 16'h0);
        i_host.frame(4'h0, 6'd16, 12'h3c5);
        chk(st(4'h0, 1'b1, 1'b1, 1'b0, 1'b1), word);
        chk({fail, mw, 2'h0, mdata}, 16'h43c5);
        i_host.frame(4'h1, 6'd16, 12'h3c5);
        chk(st(4'h1, 1'b0, 1'b0, 1'b0, 1'b1), word);
        $display("wake flags done");
        temp = 1'b0;
        dev = 1'b1;
        en = 1'b0;
        pulse(normal);
        i_host.frame(4'h1, 6'd16, 12'h3c5);
        chk(st(4'h1, 1'b0, 1'b0, 1'b0, 1'b0), word);
        $display("live status done");
        for (int i = 0; i < 4; i++)
        begin
            lf = 2'(i);
            sec = lf[0];
            i_host.frame(4'h3, 6'd16, 12'h3c5);
            chk(dg(1'b1), word);
        end
        pulse(uv);
        i_host.frame(4'h3, 6'd16, 12'h3c5);
        chk(dg(1'b0), word);
        i_host.frame(4'h3, 6'd16, 12'h3c5);
        chk(dg(1'b1), word);
        $display("diagnosis done");
        i_host.frame(4'h4, 6'd16, 12'h3c5);
        chk(word | {14'h0, hit, mw}, 16'h0);
        $display("other address done");
        complete_run();
    end
endmodule
